/* File: logic/spwe_wake_ctl.sv */
// soft-power wake-enable controller with wishbone register slave
//
// Function
// - an enable bit at one lets its source turn power on, at zero it is ignored.
// - first enable bits 0 to 3 are ring line a, ring line b, keyboard and mouse.
// - first enable bits 4 to 6 are group irq a, group irq b and infrared, bit 7 is reserved.
// - second enable bits 0 and 1 are serial receive a and b, bit 2 is reserved.
// - second enable bit 3 lets the ring wake pin raise the power-on request.
// - with force-off set, a standby reset releases the request so power stays off.
// - with force-on set and force-off clear, a standby reset drives the request low from the next clock.
// - with neither bit set, a standby reset leaves the request as it was.
// - second enable bit 7 resets to one and gates power-off by button, bit 5 is reserved.
// - latched sources record a falling edge in a status bit cleared by reading it.
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none

module spwe_wake_ctl (
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // wishbone slave
   input wire spwe_pkg::spwe_wb_req_t wb_req_i,
   output spwe_pkg::spwe_wb_rsp_t wb_rsp_o,
   // wake sources and power events
   input wire spwe_pkg::spwe_wake_pins_t wake_pins_i,
   input wire logic standby_supply_por_i,
   input wire logic power_button_i,
   // open-drain power-on request and status
   output logic power_on_request_n_o,
   output logic power_on_request_oe_n_o,
   output logic system_on_o,
   output logic irq_o
);

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   spwe_pkg::spwe_state_t state_reg;
   spwe_pkg::spwe_state_t state_next;

   logic [spwe_pkg::NUM_EDGE-1:0] edge_level;
   logic [spwe_pkg::NUM_EDGE-1:0] edge_fall;
   logic [spwe_pkg::NUM_EDGE-1:0] edge_enable;
   logic [spwe_pkg::NUM_EDGE-1:0] edge_hit;
   logic grp_hit;
   logic wake_req;
   logic button_press;
   logic off_req;
   logic standby_on_evt;
   logic standby_off_evt;
   logic wake_evt;
   logic off_evt;

   logic take;
   logic commit;
   logic [spwe_pkg::IDX_W-1:0] idx;
   logic wr_ok;
   logic rd_commit;

   logic [7:0] sts_one_set;
   logic [7:0] sts_two_set;
   logic [7:0] sts_one_clr;
   logic [7:0] sts_two_clr;
   logic [7:0] sts_one_view;
   logic [7:0] pin_view;
   logic [7:0] rbyte;

   logic [spwe_pkg::IRQ_W-1:0] irq_set;
   logic [spwe_pkg::IRQ_W-1:0] irq_status;
   logic [spwe_pkg::IRQ_W-1:0] irq_enable;
   logic irq_clr_wr;
   logic irq_en_wr;
   logic irq_line;

   // ---------------------------------------------------------------
   // wake source edges
   // ---------------------------------------------------------------
   assign edge_level = {
      wake_pins_i.ring_wake_in_n,
      wake_pins_i.serial_rx_b,
      wake_pins_i.serial_rx_a,
      wake_pins_i.infrared_rx,
      wake_pins_i.mouse_line,
      wake_pins_i.keyboard_line,
      wake_pins_i.ring_line_b,
      wake_pins_i.ring_line_a
   };

   spwe_fall_detect #(
      .W(spwe_pkg::NUM_EDGE)
   ) u_fall (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .level_i(edge_level),
      .fall_o(edge_fall)
   );

   // per-edge enable, same order as the level vector
   assign edge_enable = {
      state_reg.en_two[spwe_pkg::B2_RING],
      state_reg.en_two[spwe_pkg::B2_RX_B],
      state_reg.en_two[spwe_pkg::B2_RX_A],
      state_reg.en_one[spwe_pkg::B1_IRX],
      state_reg.en_one[spwe_pkg::B1_MOUSE],
      state_reg.en_one[spwe_pkg::B1_KBD],
      state_reg.en_one[spwe_pkg::B1_RING_B],
      state_reg.en_one[spwe_pkg::B1_RING_A]
   };

   assign edge_hit = edge_fall & edge_enable;

   // group interrupts are levels, not latched
   assign grp_hit =
      (wake_pins_i.group_irq_a & state_reg.en_one[spwe_pkg::B1_GRP_A]) |
      (wake_pins_i.group_irq_b & state_reg.en_one[spwe_pkg::B1_GRP_B]);

   assign wake_req = (|edge_hit) | grp_hit;

   // ---------------------------------------------------------------
   // power decisions
   // ---------------------------------------------------------------
   assign button_press = power_button_i & ~state_reg.button_prev & ce_i;
   assign off_req = button_press & state_reg.en_two[spwe_pkg::B2_OFF_EN];

   // force-off takes precedence should both bits ever be set
   assign standby_off_evt = standby_supply_por_i & ce_i &
      state_reg.en_two[spwe_pkg::B2_FORCE_OFF];
   assign standby_on_evt = standby_supply_por_i & ce_i &
      ~state_reg.en_two[spwe_pkg::B2_FORCE_OFF] &
      state_reg.en_two[spwe_pkg::B2_FORCE_ON];

   // standby reset overrides wake and button in its cycle
   assign wake_evt = ~standby_supply_por_i & ~state_reg.pwr_on &
      wake_req & ce_i;
   assign off_evt = ~standby_supply_por_i & state_reg.pwr_on & off_req;

   // ---------------------------------------------------------------
   // wishbone decode
   // ---------------------------------------------------------------
   assign take = wb_req_i.cyc & wb_req_i.stb & ~state_reg.ack;
   assign commit = wb_req_i.cyc & wb_req_i.stb & state_reg.ack & ce_i;
   assign idx = wb_req_i.adr[spwe_pkg::ADDR_W-1:spwe_pkg::IDX_LSB];
   assign wr_ok = commit & wb_req_i.we & wb_req_i.sel[0];
   assign rd_commit = commit & ~wb_req_i.we;

   assign irq_clr_wr = wr_ok & (idx == spwe_pkg::IDX_IRQ_CLEAR);
   assign irq_en_wr = wr_ok & (idx == spwe_pkg::IDX_IRQ_ENABLE);

   // ---------------------------------------------------------------
   // wake status latching
   // ---------------------------------------------------------------
   assign sts_one_set = {
      1'b0,
      edge_hit[4],
      2'b00,
      edge_hit[3:0]
   };
   assign sts_two_set = {
      4'h0,
      edge_hit[7],
      1'b0,
      edge_hit[6:5]
   };

   assign sts_one_clr = (rd_commit & (idx == spwe_pkg::IDX_WAKE_STS_ONE)) ?
      8'hff : 8'h00;
   assign sts_two_clr = (rd_commit & (idx == spwe_pkg::IDX_WAKE_STS_TWO)) ?
      8'hff : 8'h00;

   // group bits show the live level of their source
   assign sts_one_view = {
      state_reg.sts_one[7:6],
      wake_pins_i.group_irq_b,
      wake_pins_i.group_irq_a,
      state_reg.sts_one[3:0]
   } & spwe_pkg::STS_ONE_MASK;

   assign pin_view = edge_level;

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   always_comb begin
      rbyte = 8'h00;
      if (idx == spwe_pkg::IDX_EN_ONE) begin
         rbyte = state_reg.en_one & spwe_pkg::EN_ONE_MASK;
      end else if (idx == spwe_pkg::IDX_EN_TWO) begin
         rbyte = state_reg.en_two & spwe_pkg::EN_TWO_MASK;
      end else if (idx == spwe_pkg::IDX_WAKE_STS_ONE) begin
         rbyte = sts_one_view;
      end else if (idx == spwe_pkg::IDX_WAKE_STS_TWO) begin
         rbyte = state_reg.sts_two & spwe_pkg::STS_TWO_MASK;
      end else if (idx == spwe_pkg::IDX_IRQ_STATUS) begin
         rbyte = {4'h0, irq_status};
      end else if (idx == spwe_pkg::IDX_IRQ_ENABLE) begin
         rbyte = {4'h0, irq_enable};
      end else if (idx == spwe_pkg::IDX_POWER_STATE) begin
         rbyte = {3'b000, state_reg.last_cause, state_reg.pwr_on};
      end else if (idx == spwe_pkg::IDX_PIN_LEVEL) begin
         rbyte = pin_view;
      end
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      state_next.button_prev = power_button_i;

      // bus handshake, one ack per request
      state_next.ack = take;
      if (take) begin
         state_next.rdat = {24'h000000, rbyte};
      end

      // enable registers, reserved bits held at zero
      if (wr_ok & (idx == spwe_pkg::IDX_EN_ONE)) begin
         state_next.en_one = wb_req_i.dat[7:0] & spwe_pkg::EN_ONE_MASK;
      end
      if (wr_ok & (idx == spwe_pkg::IDX_EN_TWO)) begin
         state_next.en_two = wb_req_i.dat[7:0] & spwe_pkg::EN_TWO_MASK;
      end

      // an edge in the read cycle survives the clear
      state_next.sts_one = (state_reg.sts_one & ~sts_one_clr) |
         sts_one_set;
      state_next.sts_two = (state_reg.sts_two & ~sts_two_clr) |
         sts_two_set;

      // power state, standby reset first
      if (standby_off_evt) begin
         state_next.pwr_on = 1'b0;
         state_next.last_cause = 4'h8;
      end else if (standby_on_evt) begin
         state_next.pwr_on = 1'b1;
         state_next.last_cause = 4'h4;
      end else if (standby_supply_por_i) begin
         state_next.pwr_on = state_reg.pwr_on;
      end else if (wake_evt) begin
         state_next.pwr_on = 1'b1;
         state_next.last_cause = 4'h1;
      end else if (off_evt) begin
         state_next.pwr_on = 1'b0;
         state_next.last_cause = 4'h2;
      end
   end

   // ---------------------------------------------------------------
   // state register, reset is the battery power-on reset
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg.en_one <= spwe_pkg::EN_ONE_RST;
         state_reg.en_two <= spwe_pkg::EN_TWO_RST;
         state_reg.sts_one <= 8'h00;
         state_reg.sts_two <= 8'h00;
         state_reg.pwr_on <= 1'b0;
         state_reg.last_cause <= 4'h0;
         state_reg.button_prev <= 1'b0;
         state_reg.ack <= 1'b0;
         state_reg.rdat <= 32'h00000000;
      end else if (ce_i) begin
         state_reg <= state_next;
      end
   end

   // ---------------------------------------------------------------
   // interrupt bank
   // ---------------------------------------------------------------
   always_comb begin
      irq_set = spwe_pkg::IRQ_RST;
      irq_set[spwe_pkg::IRQ_WAKE] = wake_evt;
      irq_set[spwe_pkg::IRQ_BUTTON_OFF] = off_evt;
      irq_set[spwe_pkg::IRQ_STANDBY_ON] = standby_on_evt;
      irq_set[spwe_pkg::IRQ_STANDBY_OFF] = standby_off_evt;
   end

   spwe_irq_bank #(
      .W(spwe_pkg::IRQ_W)
   ) u_irq (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .set_i(irq_set),
      .clr_wr_i(irq_clr_wr),
      .en_wr_i(irq_en_wr),
      .wdat_i(wb_req_i.dat[spwe_pkg::IRQ_W-1:0]),
      .status_o(irq_status),
      .enable_o(irq_enable),
      .irq_o(irq_line)
   );

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign wb_rsp_o.ack = state_reg.ack;
   assign wb_rsp_o.dat = state_reg.rdat;

   // open drain: pull low while on, float while off
   assign power_on_request_n_o = 1'b0;
   assign power_on_request_oe_n_o = ~state_reg.pwr_on;
   assign system_on_o = state_reg.pwr_on;
   assign irq_o = irq_line;

endmodule : spwe_wake_ctl

`default_nettype wire

/* File: inc/spwe_pkg.sv */
// shared constants, field layouts and carrier types of the wake-enable block
package spwe_pkg;

   // ---------------------------------------------------------------
   // bus geometry
   // ---------------------------------------------------------------
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int SEL_W = 4;
   localparam int IDX_W = 8;
   localparam int IDX_LSB = 2;

   // ---------------------------------------------------------------
   // register indices, byte address is four times the index
   // ---------------------------------------------------------------
   localparam logic [7:0] IDX_EN_ONE = 8'hb0;
   localparam logic [7:0] IDX_EN_TWO = 8'hb1;
   localparam logic [7:0] IDX_WAKE_STS_ONE = 8'hb2;
   localparam logic [7:0] IDX_WAKE_STS_TWO = 8'hb3;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'hb4;
   localparam logic [7:0] IDX_IRQ_CLEAR = 8'hb5;
   localparam logic [7:0] IDX_IRQ_ENABLE = 8'hb6;
   localparam logic [7:0] IDX_POWER_STATE = 8'hb7;
   localparam logic [7:0] IDX_PIN_LEVEL = 8'hb8;

   // ---------------------------------------------------------------
   // reset values and implemented-bit masks
   // ---------------------------------------------------------------
   localparam logic [7:0] EN_ONE_RST = 8'h00;
   localparam logic [7:0] EN_TWO_RST = 8'h80;
   localparam logic [7:0] EN_ONE_MASK = 8'h7f;
   localparam logic [7:0] EN_TWO_MASK = 8'hdb;
   localparam logic [7:0] STS_ONE_MASK = 8'h7f;
   localparam logic [7:0] STS_TWO_MASK = 8'h0b;

   // ---------------------------------------------------------------
   // first enable register fields
   // ---------------------------------------------------------------
   localparam int B1_RING_A = 0;
   localparam int B1_RING_B = 1;
   localparam int B1_KBD = 2;
   localparam int B1_MOUSE = 3;
   localparam int B1_GRP_A = 4;
   localparam int B1_GRP_B = 5;
   localparam int B1_IRX = 6;

   // ---------------------------------------------------------------
   // second enable register fields
   // ---------------------------------------------------------------
   localparam int B2_RX_A = 0;
   localparam int B2_RX_B = 1;
   localparam int B2_RING = 3;
   localparam int B2_FORCE_OFF = 4;
   localparam int B2_FORCE_ON = 6;
   localparam int B2_OFF_EN = 7;

   // ---------------------------------------------------------------
   // edge-latched sources and interrupt events
   // ---------------------------------------------------------------
   localparam int NUM_EDGE = 8;
   localparam int IRQ_W = 4;
   localparam int IRQ_WAKE = 0;
   localparam int IRQ_BUTTON_OFF = 1;
   localparam int IRQ_STANDBY_ON = 2;
   localparam int IRQ_STANDBY_OFF = 3;
   localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [ADDR_W-1:0] adr;
      logic [SEL_W-1:0] sel;
      logic [DATA_W-1:0] dat;
   } spwe_wb_req_t;

   typedef struct packed {
      logic ack;
      logic [DATA_W-1:0] dat;
   } spwe_wb_rsp_t;

   typedef struct packed {
      logic ring_line_a;
      logic ring_line_b;
      logic keyboard_line;
      logic mouse_line;
      logic infrared_rx;
      logic serial_rx_a;
      logic serial_rx_b;
      logic ring_wake_in_n;
      logic group_irq_a;
      logic group_irq_b;
   } spwe_wake_pins_t;

   typedef struct packed {
      logic [7:0] en_one;
      logic [7:0] en_two;
      logic [7:0] sts_one;
      logic [7:0] sts_two;
      logic pwr_on;
      logic [IRQ_W-1:0] last_cause;
      logic button_prev;
      logic ack;
      logic [DATA_W-1:0] rdat;
   } spwe_state_t;

endpackage : spwe_pkg

/* File: logic/spwe_fall_detect.sv */
// falling-edge detector for a vector of synchronous inputs
`timescale 1ns/100ps
`default_nettype none

module spwe_fall_detect #(
   parameter int W = 8
) (
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // lines in, one-cycle edge pulses out
   input wire logic [W-1:0] level_i,
   output logic [W-1:0] fall_o
);

   typedef struct packed {
      logic [W-1:0] prev;
   } spwe_fd_state_t;

   spwe_fd_state_t state_reg;
   spwe_fd_state_t state_next;

   always_comb begin
      state_next = state_reg;
      state_next.prev = level_i;
   end

   // idle level is high, so reset to ones avoids a false edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg.prev <= '1;
      end else if (ce_i) begin
         state_reg <= state_next;
      end
   end

   assign fall_o = state_reg.prev & ~level_i & {W{ce_i}};

endmodule : spwe_fall_detect

`default_nettype wire

/* File: logic/spwe_irq_bank.sv */
// sticky event status with write-one clear, enable mask and level output
`timescale 1ns/100ps
`default_nettype none

module spwe_irq_bank #(
   parameter int W = 4
) (
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // events and software access
   input wire logic [W-1:0] set_i,
   input wire logic clr_wr_i,
   input wire logic en_wr_i,
   input wire logic [W-1:0] wdat_i,
   // state out
   output logic [W-1:0] status_o,
   output logic [W-1:0] enable_o,
   output logic irq_o
);

   typedef struct packed {
      logic [W-1:0] status;
      logic [W-1:0] enable;
      logic irq;
   } spwe_ib_state_t;

   spwe_ib_state_t state_reg;
   spwe_ib_state_t state_next;
   logic [W-1:0] clr_mask;

   always_comb begin
      state_next = state_reg;
      clr_mask = clr_wr_i ? wdat_i : '0;
      // a new event beats a clear in the same cycle
      state_next.status = (state_reg.status & ~clr_mask) | set_i;
      if (en_wr_i) begin
         state_next.enable = wdat_i;
      end
      state_next.irq = |(state_next.status & state_next.enable);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= '0;
      end else if (ce_i) begin
         state_reg <= state_next;
      end
   end

   assign status_o = state_reg.status;
   assign enable_o = state_reg.enable;
   assign irq_o = state_reg.irq;

endmodule : spwe_irq_bank

`default_nettype wire

/* File: test/spwe_wake_src.sv */
// far side model: wake source pins and supply switch
`timescale 1ns/100ps
`default_nettype none

module spwe_wake_src #(
   parameter int HOLD = 4
) (
   // clock
   input wire logic clk_i,
   // bench commands
   input wire logic [7:0] kick_i,
   input wire logic [1:0] grp_i,
   // open-drain request line
   input wire logic req_n_i,
   input wire logic req_oe_n_i,
   // pins and supply
   output spwe_pkg::spwe_wake_pins_t pins_o,
   output logic supply_on_o
);
   int cnt [8] = '{default: 0};
   logic [7:0] low;

   // a kicked line stays low for HOLD cycles, then idles high
   always @(posedge clk_i) begin
      foreach (cnt[i]) begin
         if (kick_i[i]) begin
            cnt[i] <= HOLD;
         end else if (cnt[i] > 0) begin
            cnt[i] <= cnt[i] - 1;
         end
      end
   end
   always_comb begin
      foreach (low[i]) low[i] = (cnt[i] != 0);
   end
   assign pins_o = {~low[0], ~low[1], ~low[2], ~low[3], ~low[4], ~low[5],
      ~low[6], ~low[7], grp_i[0], grp_i[1]};
   // released line is pulled up, so the supply stays off
   assign supply_on_o = ~req_oe_n_i & ~req_n_i;
endmodule : spwe_wake_src
`default_nettype wire

/* File: test/spwe_wake_ctl_assertions.sv */
// concurrent checks at the ports of the wake-enable controller
`timescale 1ns/100ps
`default_nettype none

module spwe_wake_ctl_chk (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // bus and events
   input wire spwe_pkg::spwe_wb_req_t wb_req_i,
   input wire spwe_pkg::spwe_wb_rsp_t wb_rsp_o,
   input wire spwe_pkg::spwe_wake_pins_t wake_pins_i,
   input wire logic standby_supply_por_i,
   input wire logic power_button_i,
   // power state
   input wire logic power_on_request_oe_n_o,
   input wire logic system_on_o
);
   logic [7:0] e1_reg;
   logic [7:0] e2_reg;
   logic wr_en;
   logic por;
   logic off;
   logic on;
   assign wr_en = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we
      & wb_req_i.sel[0] & wb_rsp_o.ack & ce_i;
   assign por = standby_supply_por_i & ce_i;
   assign off = ~system_on_o & ~standby_supply_por_i & ce_i;
   assign on = system_on_o & ~standby_supply_por_i & ce_i;
   // shadow of the enables, committed at the ack edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         e1_reg <= spwe_pkg::EN_ONE_RST;
         e2_reg <= spwe_pkg::EN_TWO_RST;
      end else if (wr_en && wb_req_i.adr[9:2] == spwe_pkg::IDX_EN_ONE) begin
         e1_reg <= wb_req_i.dat[7:0] & spwe_pkg::EN_ONE_MASK;
      end else if (wr_en && wb_req_i.adr[9:2] == spwe_pkg::IDX_EN_TWO) begin
         e2_reg <= wb_req_i.dat[7:0] & spwe_pkg::EN_TWO_MASK;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_ack_latency: assert property (wb_req_i.cyc && wb_req_i.stb
      && !wb_rsp_o.ack && ce_i |=> wb_rsp_o.ack) else $error("ack late");
   a_ack_single: assert property (wb_rsp_o.ack && ce_i |=> !wb_rsp_o.ack)
      else $error("ack longer than one cycle");
   a_oe_follows_on: assert property (
      power_on_request_oe_n_o == !system_on_o) else $error("oe_n vs on");
   a_standby_off: assert property (por && e2_reg[4] |=>
      power_on_request_oe_n_o) else $error("force-off ignored");
   a_standby_on: assert property (por && e2_reg[6] && !e2_reg[4] |=>
      !power_on_request_oe_n_o) else $error("force-on ignored");
   a_standby_keeps: assert property (por && !e2_reg[4] && !e2_reg[6]
      |=> $stable(power_on_request_oe_n_o)) else $error("request moved");
   a_ring_pin_wakes: assert property (off && e2_reg[3]
      && $fell(wake_pins_i.ring_wake_in_n) |=> system_on_o)
      else $error("ring pin did not wake");
   a_keyboard_wakes: assert property (off && e1_reg[2]
      && $fell(wake_pins_i.keyboard_line) |=> system_on_o)
      else $error("keyboard did not wake");
   a_masked_quiet: assert property (off && e1_reg == 8'h00
      && e2_reg[3:0] == 4'h0 |=> !system_on_o) else $error("masked wake");
   a_button_gated: assert property (on && !e2_reg[7]
      && $rose(power_button_i) |=> system_on_o) else $error("button off");
   a_button_offs: assert property (on && e2_reg[7]
      && $rose(power_button_i) |=> !system_on_o) else $error("still on");
endmodule : spwe_wake_ctl_chk

bind spwe_wake_ctl spwe_wake_ctl_chk chk_u (
   .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
   .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .wake_pins_i(wake_pins_i),
   .standby_supply_por_i(standby_supply_por_i),
   .power_button_i(power_button_i),
   .power_on_request_oe_n_o(power_on_request_oe_n_o),
   .system_on_o(system_on_o)
);
`default_nettype wire

/* File: test/spwe_wake_ctl_test.sv */
// self-checking bench of the wake-enable controller
`timescale 1ns/100ps
`default_nettype none

module spwe_wake_ctl_test;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic por = 1'b0;
   logic btn = 1'b0;
   logic [7:0] kick = 8'h00;
   logic [1:0] grp = 2'b00;
   spwe_pkg::spwe_wb_req_t req = '0;
   spwe_pkg::spwe_wb_rsp_t rsp;
   spwe_pkg::spwe_wake_pins_t pins;
   logic req_n;
   logic oe_n;
   logic on;
   logic irq;
   logic sup;
   int miscompares = 0;
   int samples_checked = 0;
   int ticks = 0;
   int bp [8] = '{0, 1, 2, 3, 6, 0, 1, 3};

   always #10 clk_i = ~clk_i;

   spwe_wake_ctl dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
      .wb_req_i(req), .wb_rsp_o(rsp), .wake_pins_i(pins),
      .standby_supply_por_i(por), .power_button_i(btn),
      .power_on_request_n_o(req_n), .power_on_request_oe_n_o(oe_n),
      .system_on_o(on), .irq_o(irq));
   spwe_wake_src src_u (.clk_i(clk_i), .kick_i(kick), .grp_i(grp),
      .req_n_i(req_n), .req_oe_n_i(oe_n), .pins_o(pins),
      .supply_on_o(sup));

   // ----------------------------------------------------------
   // bus cycles and checks
   // ----------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] ex,
      input logic [7:0] got);
      samples_checked++;
      if (got !== ex) begin
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
         miscompares++;
      end
   endtask : chk

   task automatic bus(input logic we, input logic [7:0] idx,
      input logic [7:0] wd, output logic [7:0] rd);
      req <= '{1'b1, 1'b1, we, {idx, 2'b00}, 4'h1, {24'h0, wd}};
      @(posedge clk_i);
      while (rsp.ack !== 1'b1) begin
         @(posedge clk_i);
      end
      rd = rsp.dat[7:0];
      req <= '0;
      @(posedge clk_i);
   endtask : bus

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] x;
      bus(1'b1, idx, d, x);
   endtask : wr

   task automatic rd_chk(input string nm, input logic [7:0] idx,
      input logic [7:0] ex);
      logic [7:0] x;
      bus(1'b0, idx, 8'h00, x);
      chk(nm, ex, x);
   endtask : rd_chk

   task automatic pwr(input logic ex);
      #1;
      chk("system_on", {7'h0, ex}, {7'h0, on});
      chk("oe_n", {7'h0, !ex}, {7'h0, oe_n});
      chk("supply", {7'h0, ex}, {7'h0, sup});
      @(posedge clk_i);
   endtask : pwr

   task automatic pulse(input int sel);
      if (sel < 8) kick <= 8'h01 << sel;
      else if (sel == 8) btn <= 1'b1;
      else por <= 1'b1;
      @(posedge clk_i);
      kick <= 8'h00;
      btn <= 1'b0;
      por <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask : pulse

   // ----------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------
   task automatic t_regs();
      pwr(1'b0);
      rd_chk("en_one reset", spwe_pkg::IDX_EN_ONE, 8'h00);
      rd_chk("en_two reset", spwe_pkg::IDX_EN_TWO, 8'h80);
      rd_chk("pin level", spwe_pkg::IDX_PIN_LEVEL, 8'hff);
      wr(8'h10, 8'h55);
      rd_chk("unmapped", 8'h10, 8'h00);
      wr(spwe_pkg::IDX_EN_ONE, 8'hff);
      rd_chk("en_one bit7", spwe_pkg::IDX_EN_ONE, 8'h7f);
      wr(spwe_pkg::IDX_EN_TWO, 8'h24);
      rd_chk("en_two reserved", spwe_pkg::IDX_EN_TWO, 8'h00);
   endtask : t_regs

   task automatic t_sources();
      logic [7:0] ri;
      logic [7:0] v;
      for (int i = 0; i < 8; i++) begin
         ri = (i < 5) ? spwe_pkg::IDX_EN_ONE : spwe_pkg::IDX_EN_TWO;
         v = 8'h01 << bp[i];
         wr(spwe_pkg::IDX_EN_ONE, 8'h00);
         wr(spwe_pkg::IDX_EN_TWO, 8'h80);
         pulse(i);
         pwr(1'b0);
         wr(ri, (i < 5) ? v : (v | 8'h80));
         pulse(i);
         pwr(1'b1);
         rd_chk("wake status", ri + 8'h02, v);
         rd_chk("status reread", ri + 8'h02, 8'h00);
         pulse(8);
         pwr(1'b0);
      end
      for (int g = 0; g < 2; g++) begin
         wr(spwe_pkg::IDX_EN_ONE, 8'h10 << g);
         grp <= 2'b01 << g;
         repeat (3) @(posedge clk_i);
         pwr(1'b1);
         rd_chk("group live", spwe_pkg::IDX_WAKE_STS_ONE, 8'h10 << g);
         grp <= 2'b00;
         pulse(8);
         pwr(1'b0);
      end
      wr(spwe_pkg::IDX_EN_ONE, 8'h00);
   endtask : t_sources

   task automatic t_standby();
      wr(spwe_pkg::IDX_EN_TWO, 8'hc0);
      pulse(9);
      pwr(1'b1);
      rd_chk("power state", spwe_pkg::IDX_POWER_STATE, 8'h09);
      wr(spwe_pkg::IDX_EN_TWO, 8'h80);
      pulse(9);
      pwr(1'b1);
      wr(spwe_pkg::IDX_EN_TWO, 8'h90);
      pulse(9);
      pwr(1'b0);
      rd_chk("power state", spwe_pkg::IDX_POWER_STATE, 8'h10);
      wr(spwe_pkg::IDX_EN_TWO, 8'h80);
      pulse(9);
      pwr(1'b0);
      wr(spwe_pkg::IDX_EN_TWO, 8'h08);
      pulse(7);
      pulse(8);
      pwr(1'b1);
      wr(spwe_pkg::IDX_EN_TWO, 8'h88);
      pulse(8);
      pwr(1'b0);
   endtask : t_standby

   task automatic t_irq();
      wr(spwe_pkg::IDX_IRQ_CLEAR, 8'h0f);
      wr(spwe_pkg::IDX_IRQ_ENABLE, 8'h02);
      pulse(7);
      chk("irq masked", 8'h00, {7'h0, irq});
      pulse(8);
      chk("irq raised", 8'h01, {7'h0, irq});
      rd_chk("irq status", spwe_pkg::IDX_IRQ_STATUS, 8'h03);
      rd_chk("irq clear reg", spwe_pkg::IDX_IRQ_CLEAR, 8'h00);
      wr(spwe_pkg::IDX_IRQ_CLEAR, 8'h03);
      #1;
      chk("irq cleared", 8'h00, {7'h0, irq});
      rd_chk("irq status clr", spwe_pkg::IDX_IRQ_STATUS, 8'h00);
      // frozen block must miss an enabled edge
      ce_i <= 1'b0;
      pulse(7);
      pwr(1'b0);
      ce_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      pwr(1'b0);
   endtask : t_irq

   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run

   always @(posedge clk_i) begin
      ticks <= ticks + 1;
      if (ticks == 20000) begin
         miscompares++;
         complete_run();
      end
   end

   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs();
      t_sources();
      t_standby();
      t_irq();
      complete_run();
   end
endmodule : spwe_wake_ctl_test
`default_nettype wire
